// File: core/jtir_map.vh
`ifndef JTIR_MAP_VH
`define JTIR_MAP_VH

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define JTIR_IR_W 3
`define JTIR_EXTERNAL 3'h0
`define JTIR_IDENT 3'h1
`define JTIR_SAMPLE 3'h4
`define JTIR_FLOAT 3'h5
`define JTIR_HOLD 3'h6
`define JTIR_PASS 3'h7
`define JTIR_IR_RESET 3'h1
`define JTIR_IR_CAPTURE 3'h1

// ----------------------------------------
// Identification and boundary chain
// ----------------------------------------
`define JTIR_ID_W 32
`define JTIR_PINS 4
`define JTIR_BSR_W 12
`define JTIR_CELL_CTL 0
`define JTIR_CELL_OUT 1
`define JTIR_CELL_IN 2
`define JTIR_SYNC_W 8

`endif

// File: core/jtir_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "jtir_map.vh"

// ----------------------------------------
// Pin synchroniser and edge finder
// ----------------------------------------
module jtir_sync #(
   parameter W = 8
) (
   input wire clk,
   input wire rst,
   input wire [W-1:0] din,
   output reg [W-1:0] lvl_reg,
   output wire [W-1:0] rise,
   output wire [W-1:0] fall
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;
   wire [W-1:0] agree;

   // A change counts only once the second and third stages agree.
   assign agree = ~(s2_reg ^ s3_reg);
   assign rise = agree & s3_reg & ~lvl_reg;
   assign fall = agree & ~s3_reg & lvl_reg;

   always @(posedge clk) begin
      if (rst) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
         s3_reg <= {W{1'b0}};
         lvl_reg <= {W{1'b0}};
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         lvl_reg <= (agree & s3_reg) | (~agree & lvl_reg);
      end
   end
endmodule // jtir_sync

// ----------------------------------------
// Test port: TAP, instruction register, data registers
// ----------------------------------------
module jtir_decode #(
   // Arbitrary identity value; bit 0 must stay one.
   parameter [31:0] ID_VALUE = 32'h0000_0001
) (
   input wire clk,
   input wire rst,
   input wire tck,
   input wire tms,
   input wire tdi,
   input wire trst_n,
   output reg tdo,
   output reg tdo_oe_n,
   input wire [`JTIR_PINS-1:0] core_out,
   input wire [`JTIR_PINS-1:0] core_oe,
   input wire [`JTIR_PINS-1:0] pad_in,
   output reg [`JTIR_PINS-1:0] pad_out,
   output reg [`JTIR_PINS-1:0] pad_oe_n,
   output reg func_reset,
   output wire [`JTIR_IR_W-1:0] active_instr
);
   localparam [15:0] S_TLR = 16'h0001;
   localparam [15:0] S_RTI = 16'h0002;
   localparam [15:0] S_SEL_DR = 16'h0004;
   localparam [15:0] S_CAP_DR = 16'h0008;
   localparam [15:0] S_SH_DR = 16'h0010;
   localparam [15:0] S_EX1_DR = 16'h0020;
   localparam [15:0] S_PA_DR = 16'h0040;
   localparam [15:0] S_EX2_DR = 16'h0080;
   localparam [15:0] S_UPD_DR = 16'h0100;
   localparam [15:0] S_SEL_IR = 16'h0200;
   localparam [15:0] S_CAP_IR = 16'h0400;
   localparam [15:0] S_SH_IR = 16'h0800;
   localparam [15:0] S_EX1_IR = 16'h1000;
   localparam [15:0] S_PA_IR = 16'h2000;
   localparam [15:0] S_EX2_IR = 16'h4000;
   localparam [15:0] S_UPD_IR = 16'h8000;

   wire [`JTIR_SYNC_W-1:0] lvl;
   wire [`JTIR_SYNC_W-1:0] rise;
   wire [`JTIR_SYNC_W-1:0] fall;
   wire tck_rise;
   wire tck_fall;
   wire tms_s;
   wire tdi_s;
   wire trst_s_n;
   wire [`JTIR_PINS-1:0] pad_in_s;

   reg [15:0] state_reg;
   reg [15:0] state_next;
   reg [`JTIR_IR_W-1:0] ir_shift_reg;
   reg [`JTIR_IR_W-1:0] ir_hold_reg;
   reg [`JTIR_ID_W-1:0] id_reg;
   reg bypass_reg;
   reg [`JTIR_BSR_W-1:0] bsr_reg;
   reg [`JTIR_BSR_W-1:0] upd_reg;

   wire sel_bsr;
   wire sel_id;
   wire drive_cells;
   reg dr_lsb;
   integer i;
   integer j;

   jtir_sync #(.W(`JTIR_SYNC_W)) u_sync (
      .clk(clk),
      .rst(rst),
      .din({pad_in, trst_n, tdi, tms, tck}),
      .lvl_reg(lvl),
      .rise(rise),
      .fall(fall)
   );

   assign tck_rise = rise[0];
   assign tck_fall = fall[0];
   assign tms_s = lvl[1];
   assign tdi_s = lvl[2];
   assign trst_s_n = lvl[3];
   assign pad_in_s = lvl[7:4];
   assign active_instr = ir_hold_reg;

   // ----------------------------------------
   // Instruction decode
   // ----------------------------------------
   // Codes 010 and 011 fall through to the bypass bit.
   assign sel_bsr = (ir_hold_reg == `JTIR_EXTERNAL)
      || (ir_hold_reg == `JTIR_SAMPLE);
   assign sel_id = (ir_hold_reg == `JTIR_IDENT);
   assign drive_cells = (ir_hold_reg == `JTIR_EXTERNAL) || (ir_hold_reg == `JTIR_HOLD);

   always @* begin
      if (sel_bsr) begin
         dr_lsb = bsr_reg[0];
      end else if (sel_id) begin
         dr_lsb = id_reg[0];
      end else begin
         dr_lsb = bypass_reg;
      end
   end

   // ----------------------------------------
   // TAP state machine
   // ----------------------------------------
   // Five TMS-high edges lead to reset from any state.
   always @* begin
      case (state_reg)
         S_TLR: state_next = tms_s ? S_TLR : S_RTI;
         S_RTI: state_next = tms_s ? S_SEL_DR : S_RTI;
         S_SEL_DR: state_next = tms_s ? S_SEL_IR : S_CAP_DR;
         S_CAP_DR: state_next = tms_s ? S_EX1_DR : S_SH_DR;
         S_SH_DR: state_next = tms_s ? S_EX1_DR : S_SH_DR;
         S_EX1_DR: state_next = tms_s ? S_UPD_DR : S_PA_DR;
         S_PA_DR: state_next = tms_s ? S_EX2_DR : S_PA_DR;
         S_EX2_DR: state_next = tms_s ? S_UPD_DR : S_SH_DR;
         S_UPD_DR: state_next = tms_s ? S_SEL_DR : S_RTI;
         S_SEL_IR: state_next = tms_s ? S_TLR : S_CAP_IR;
         S_CAP_IR: state_next = tms_s ? S_EX1_IR : S_SH_IR;
         S_SH_IR: state_next = tms_s ? S_EX1_IR : S_SH_IR;
         S_EX1_IR: state_next = tms_s ? S_UPD_IR : S_PA_IR;
         S_PA_IR: state_next = tms_s ? S_EX2_IR : S_PA_IR;
         S_EX2_IR: state_next = tms_s ? S_UPD_IR : S_SH_IR;
         S_UPD_IR: state_next = tms_s ? S_SEL_DR : S_RTI;
         default: state_next = S_TLR;
      endcase
   end

   // ----------------------------------------
   // Rising TCK edge: state, capture and shift
   // ----------------------------------------
   // TDI is taken from the stable sampled level, so it must settle first.
   always @(posedge clk) begin
      if (rst || !trst_s_n) begin
         state_reg <= S_TLR;
         ir_shift_reg <= `JTIR_IR_RESET;
         id_reg <= {`JTIR_ID_W{1'b0}};
         bypass_reg <= 1'b0;
         bsr_reg <= {`JTIR_BSR_W{1'b0}};
      end else if (tck_rise) begin
         state_reg <= state_next;
         if (state_reg == S_CAP_IR) begin
            ir_shift_reg <= `JTIR_IR_CAPTURE;
         end else if (state_reg == S_SH_IR) begin
            ir_shift_reg <= {tdi_s, ir_shift_reg[`JTIR_IR_W-1:1]};
         end
         if (state_reg == S_CAP_DR) begin
            id_reg <= ID_VALUE | 32'h0000_0001;
            bypass_reg <= 1'b0;
            if (sel_bsr) begin
               // Capture only observes pins; system paths are never touched.
               for (i = 0; i < `JTIR_PINS; i = i + 1) begin
                  bsr_reg[3*i+`JTIR_CELL_CTL] <= core_oe[i];
                  bsr_reg[3*i+`JTIR_CELL_OUT] <= core_out[i];
                  bsr_reg[3*i+`JTIR_CELL_IN] <= pad_in_s[i];
               end
            end
         end else if (state_reg == S_SH_DR) begin
            if (sel_bsr) begin
               bsr_reg <= {tdi_s, bsr_reg[`JTIR_BSR_W-1:1]};
            end else if (sel_id) begin
               id_reg <= {tdi_s, id_reg[`JTIR_ID_W-1:1]};
            end else begin
               bypass_reg <= tdi_s;
            end
         end
      end
   end

   // ----------------------------------------
   // Falling TCK edge: hold stage, update cells, TDO
   // ----------------------------------------
   // TCK is not locked to clk, so sampled data is only meaningful if the tester aligns it.
   always @(posedge clk) begin
      if (rst || !trst_s_n) begin
         ir_hold_reg <= `JTIR_IR_RESET;
         upd_reg <= {`JTIR_BSR_W{1'b0}};
         tdo <= 1'b0;
         tdo_oe_n <= 1'b1;
      end else if (tck_fall) begin
         if (state_reg == S_TLR) begin
            ir_hold_reg <= `JTIR_IR_RESET;
         end else if (state_reg == S_UPD_IR) begin
            ir_hold_reg <= ir_shift_reg;
         end
         if (state_reg == S_UPD_DR && sel_bsr) begin
            upd_reg <= bsr_reg;
         end
         if (state_reg == S_SH_IR) begin
            tdo <= ir_shift_reg[0];
            tdo_oe_n <= 1'b0;
         end else if (state_reg == S_SH_DR) begin
            tdo <= dr_lsb;
            tdo_oe_n <= 1'b0;
         end else begin
            tdo_oe_n <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Pad control
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         pad_out <= {`JTIR_PINS{1'b0}};
         pad_oe_n <= {`JTIR_PINS{1'b1}};
         func_reset <= 1'b0;
      end else begin
         func_reset <= (ir_hold_reg == `JTIR_HOLD);
         for (j = 0; j < `JTIR_PINS; j = j + 1) begin
            if (ir_hold_reg == `JTIR_FLOAT) begin
               pad_out[j] <= core_out[j];
               pad_oe_n[j] <= 1'b1;
            end else if (drive_cells) begin
               pad_out[j] <= upd_reg[3*j+`JTIR_CELL_OUT];
               pad_oe_n[j] <= ~upd_reg[3*j+`JTIR_CELL_CTL];
            end else begin
               pad_out[j] <= core_out[j];
               pad_oe_n[j] <= ~core_oe[j];
            end
         end
      end
   end
endmodule // jtir_decode

`default_nettype wire

// File: sim/jtir_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "jtir_map.vh"
module jtir_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   input wire logic tdo,
   input wire logic tdo_oe_n,
   input wire logic [3:0] core_out,
   input wire logic [3:0] core_oe,
   input wire logic [3:0] pad_in,
   input wire logic [3:0] pad_out,
   input wire logic [3:0] pad_oe_n,
   input wire logic func_reset,
   input wire logic [2:0] active_instr
);
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_FLOAT: assert property (active_instr == `JTIR_FLOAT |=> pad_oe_n == 4'hF)
      else $error("float code left a pad driven");
   AST_NORMAL: assert property (!(active_instr inside {`JTIR_EXTERNAL,
      `JTIR_FLOAT, `JTIR_HOLD}) |=> pad_out == $past(core_out)
      && pad_oe_n == ~$past(core_oe))
      else $error("pads not in normal operation");
   AST_HOLD_PADS: assert property (active_instr == `JTIR_HOLD && $past(active_instr) == `JTIR_HOLD
      |=> $stable(pad_out) && $stable(pad_oe_n))
      else $error("clamped pads moved");
   AST_CLAMP_RST: assert property (1'b1 |=> func_reset == ($past(active_instr) == `JTIR_HOLD))
      else $error("functional reset does not follow clamp");
   AST_TRST: assert property (!trst_n [*6] |=> active_instr == `JTIR_IDENT && tdo_oe_n)
      else $error("test reset did not restore identify");
   AST_TDO_QUIET: assert property (tdo_oe_n && $past(tdo_oe_n) && trst_n |-> $stable(tdo))
      else $error("tdo moved while released");
   // The pin synchroniser delays the response by four clocks, so with a 40 ns low phase
   // the change may land as the next rise starts; the check looks back at the fall itself.
   AST_TDO_EDGE: assert property ($changed(tdo)
      |-> !trst_n || (!$past(tck, 2) && $past(tck, 5)))
      else $error("tdo changed away from a tck fall");
   AST_OE_EDGE: assert property ($changed(tdo_oe_n)
      |-> !trst_n || (!$past(tck, 2) && $past(tck, 5)))
      else $error("tdo enable changed away from a tck fall");
endmodule // jtir_assertions
bind jtir_decode jtir_assertions jtir_assertions_i(.clk(clk), .rst(rst), .tck(tck), .tms(tms),
   .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .core_out(core_out),
   .core_oe(core_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
   .func_reset(func_reset), .active_instr(active_instr));
`default_nettype wire

// File: sim/jtir_tester.sv
`timescale 1ns/1ps
`default_nettype none
module jtir_tester (
   input wire logic clk,
   input wire logic tdo,
   input wire logic tdo_oe_n,
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_n
);
   // ----------
   // Tester steps
   // ----------
   // A released TDO reads as the inverse of its last value, never a stale match.
   wire line = tdo_oe_n ? ~tdo : tdo;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      trst_n = 1'b1;
   end
   // One step is one 80 ns TCK period; TCK stands low between steps.
   // TDO is read just after the rise, so it shows what the previous fall launched.
   task automatic step(input logic m, input logic d, output logic o);
      @(posedge clk);
      tms <= m;
      tdi <= d;
      repeat (3) @(posedge clk);
      tck <= 1'b1;
      @(posedge clk);
      o = line;
      repeat (3) @(posedge clk);
      tck <= 1'b0;
   endtask
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
      output logic [31:0] o);
      logic b;
      o = 32'h0;
      step(1'b0, 1'b0, b);
      step(1'b1, 1'b0, b);
      if (ir) step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
      step(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], b);
         o[i] = b;
      end
      step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
   endtask
   task automatic treset();
      @(posedge clk);
      trst_n <= 1'b0;
      repeat (8) @(posedge clk);
      trst_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
endmodule // jtir_tester
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "jtir_map.vh"
module tb;
   // ----------
   // Bench
   // ----------
   localparam [31:0] IDV = 32'h5A3C_96E1; // Arbitrary identity value.
   logic clk, rst, b;
   logic [3:0] core_out, core_oe, pad_in;
   wire tck, tms, tdi, trst_n, tdo, tdo_oe_n, func_reset;
   wire [3:0] pad_out, pad_oe_n;
   wire [2:0] active_instr;
   int fails, tests_run, cyc, n;
   logic [31:0] q, r, m;
   logic [11:0] d;
   jtir_decode #(.ID_VALUE(IDV)) jtir_decode_i(.clk(clk), .rst(rst), .tck(tck), .tms(tms),
      .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .core_out(core_out),
      .core_oe(core_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .func_reset(func_reset), .active_instr(active_instr));
   jtir_tester jtir_tester_i(.clk(clk), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tck(tck), .tms(tms),
      .tdi(tdi), .trst_n(trst_n));
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   task wrap_up();
      $display("checks %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Update cells drive the pads only under external test and clamp.
   function automatic logic [7:0] pads(input logic [2:0] c, input logic [11:0] u);
      logic [7:0] p;
      p = {~core_oe, core_out};
      if (c == `JTIR_EXTERNAL || c == `JTIR_HOLD)
         for (int i = 0; i < 4; i++) begin
            p[i] = u[3*i+1];
            p[i+4] = ~u[3*i];
         end
      // Float releases every pad whatever the core asks for.
      if (c == `JTIR_FLOAT) p[7:4] = 4'hF;
      return p;
   endfunction
   function automatic logic [31:0] dexp(input logic [2:0] c);
      logic [31:0] x;
      x = 32'h0;
      if (c == `JTIR_IDENT) x = IDV;
      if (c == `JTIR_EXTERNAL || c == `JTIR_SAMPLE)
         for (int i = 0; i < 4; i++) begin
            x[3*i+1] = core_out[i];
            x[3*i+2] = pad_in[i];
         end
      return x;
   endfunction
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      rst = 1'b1;
      core_out = 4'h0;
      core_oe = 4'h0;
      pad_in = 4'h0;
      fails = 0;
      tests_run = 0;
      q = $urandom(32'hECF75EB7);
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      chk("reset instr", `JTIR_IDENT, active_instr);
      chk("reset tdo oe", 1, tdo_oe_n);
      jtir_tester_i.scan(1'b0, 32, 32'h0, q);
      chk("identity", IDV, q);
      d = $urandom;
      jtir_tester_i.scan(1'b1, 3, {29'h0, `JTIR_SAMPLE}, q);
      jtir_tester_i.scan(1'b0, 12, {20'h0, d}, q);
      $display("test preload done");
      for (int c = 0; c < 8; c++) begin
         @(posedge clk);
         core_out <= $urandom;
         core_oe <= $urandom;
         pad_in <= $urandom;
         jtir_tester_i.scan(1'b1, 3, {29'h0, c[2:0]}, q);
         chk("ir capture", 1, q);
         chk("instr", c, active_instr);
         r = pads(c[2:0], d);
         chk("pad oe", r[7:4], pad_oe_n);
         if (c != `JTIR_FLOAT) chk("pad out", r[3:0], pad_out);
         chk("func reset", c == `JTIR_HOLD, func_reset);
         n = (c == 1) ? 32 : (c == 0 || c == 4) ? 12 : 1;
         m = (c == 0 || c == 4) ? 32'h0000_0DB6 : 32'hFFFF_FFFF;
         r = dexp(c[2:0]);
         jtir_tester_i.scan(1'b0, n, {20'h0, d}, q);
         chk("dr out", r & m, q & m);
         $display("test code %0d done", c);
      end
      jtir_tester_i.scan(1'b1, 3, {29'h0, `JTIR_PASS}, q);
      for (int i = 0; i < 5; i++) jtir_tester_i.step(1'b1, 1'b0, b);
      chk("tms reset", `JTIR_IDENT, active_instr);
      jtir_tester_i.scan(1'b1, 3, {29'h0, `JTIR_FLOAT}, q);
      jtir_tester_i.treset();
      chk("trst instr", `JTIR_IDENT, active_instr);
      chk("trst pads", {~core_oe, core_out}, {pad_oe_n, pad_out});
      $display("test resets done");
      wrap_up();
   end
endmodule // tb
`default_nettype wire
